// *** logic/dsp_regs_pkg.sv ***
// Shared constants and field carriers for the sound chain registers
package dsp_regs_pkg;

  // Register addresses on the control port
  localparam logic [7:0] ADDR_PROT_BYPASS = 8'h0F;
  localparam logic [7:0] ADDR_COMPRESSOR = 8'h10;
  localparam logic [7:0] ADDR_TONE = 8'h11;

  // Protection and bypass field positions
  localparam int OC_RETRY_LSB = 6;
  localparam int OT_RETRY_LSB = 4;
  localparam int SOFT_CLIP_BIT = 3;
  localparam int HIGHPASS_BIT = 2;
  localparam int COMPRESSOR_BIT = 1;
  localparam int EQUALIZER_BIT = 0;

  // Compressor field positions
  localparam int ONSET_LEVEL_LSB = 12;
  localparam int ONSET_SPEED_LSB = 8;
  localparam int RELEASE_LEVEL_LSB = 4;
  localparam int RELEASE_SPEED_LSB = 0;

  // Tone field positions
  localparam int HIGH_GAIN_LSB = 9;
  localparam int HIGH_CORNER_LSB = 7;
  localparam int LOW_GAIN_LSB = 2;
  localparam int LOW_CORNER_LSB = 0;

  // Reset values
  localparam logic [1:0] OC_RETRY_RST = 2'h2;
  localparam logic [1:0] OT_RETRY_RST = 2'h1;
  localparam logic SOFT_CLIP_RST = 1'b0;
  localparam logic HIGHPASS_RST = 1'b0;
  localparam logic COMPRESSOR_RST = 1'b1;
  localparam logic EQUALIZER_RST = 1'b1;
  localparam logic [3:0] ONSET_LEVEL_RST = 4'h9;
  localparam logic [3:0] ONSET_SPEED_RST = 4'h2;
  localparam logic [3:0] RELEASE_LEVEL_RST = 4'hB;
  localparam logic [3:0] RELEASE_SPEED_RST = 4'hA;
  localparam logic [4:0] SHELF_GAIN_RST = 5'h09;
  localparam logic [1:0] SHELF_CORNER_RST = 2'h1;

  // Tone gain encoding
  localparam logic [4:0] SHELF_GAIN_MAX_CODE = 5'h12;
  localparam logic signed [5:0] SHELF_GAIN_MIN_DB = -6'sd18;
  localparam logic signed [5:0] SHELF_GAIN_ZERO_DB = 6'sd0;

  // Retry selector that never recovers
  localparam logic [1:0] RETRY_HOLD = 2'h3;

  // Float times and their cycle counts at the 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int FLOAT_SHORT_NS = 4500;
  localparam int OC_MID_NS = 27500;
  localparam int OC_LONG_MS = 10;
  localparam int OT_MID_MS = 100;
  localparam int OT_LONG_S = 1;
  localparam int FLOAT_SHORT_CYC =
    (FLOAT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_MID_CYC = (OC_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_LONG_CYC =
    (OC_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OT_MID_CYC =
    (OT_MID_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OT_LONG_CYC =
    (OT_LONG_S * 1000000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] overcurrent_retry_delay;
    logic [1:0] overtemp_retry_delay;
    logic soft_clip_disable;
    logic highpass_skip;
    logic compressor_skip;
    logic equalizer_skip;
  } protect_bypass_t;

  typedef struct packed {
    logic [3:0] compress_onset_level;
    logic [3:0] compress_onset_speed;
    logic [3:0] compress_release_level;
    logic [3:0] compress_release_speed;
  } compressor_t;

  typedef struct packed {
    logic [4:0] high_shelf_gain;
    logic [1:0] high_shelf_corner;
    logic [4:0] low_shelf_gain;
    logic [1:0] low_shelf_corner;
  } tone_t;

  typedef enum logic [1:0] {
    FLOAT_IDLE,
    FLOAT_TIMED,
    FLOAT_HELD
  } float_state_t;

endpackage

// *** logic/tone_gain_decode.sv ***
// Shelf gain code to signed decibel value
`timescale 1ns/1ns
module tone_gain_decode (
  input wire logic [4:0] code,
  output logic signed [5:0] gain_db
);

  always_comb begin
    if (code > dsp_regs_pkg::SHELF_GAIN_MAX_CODE) begin
      // Out-of-range codes fall back to flat rather than an odd gain
      gain_db = dsp_regs_pkg::SHELF_GAIN_ZERO_DB;
    end else begin
      gain_db = dsp_regs_pkg::SHELF_GAIN_MIN_DB
        + $signed({code, 1'b0});
    end
  end

endmodule

// *** logic/audio_dsp_bypass_tone_regs.sv ***
// Sound chain configuration registers with protection float timer
`timescale 1ns/1ns
module audio_dsp_bypass_tone_regs #(
  parameter int CNT_W = 25,
  parameter int OC_LONG_CYCLES = dsp_regs_pkg::OC_LONG_CYC,
  parameter int OT_MID_CYCLES = dsp_regs_pkg::OT_MID_CYC,
  parameter int OT_LONG_CYCLES = dsp_regs_pkg::OT_LONG_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic overcurrent_event,
  input wire logic overtemp_event,
  output logic stage_float,
  output dsp_regs_pkg::protect_bypass_t cfg_bypass,
  output dsp_regs_pkg::compressor_t cfg_compressor,
  output dsp_regs_pkg::tone_t cfg_tone,
  output logic signed [5:0] high_shelf_db,
  output logic signed [5:0] low_shelf_db
);

  localparam int SHORT_CYC = dsp_regs_pkg::FLOAT_SHORT_CYC;

  dsp_regs_pkg::protect_bypass_t bypass_reg;
  dsp_regs_pkg::compressor_t comp_reg;
  dsp_regs_pkg::tone_t tone_reg;
  dsp_regs_pkg::float_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic signed [5:0] high_db_reg;
  logic signed [5:0] low_db_reg;
  logic signed [5:0] high_db_next;
  logic signed [5:0] low_db_next;
  logic [CNT_W-1:0] oc_load;
  logic [CNT_W-1:0] ot_load;
  logic oc_hold;
  logic ot_hold;

  // Float length in clock cycles for one fault kind and selector
  function automatic logic [CNT_W-1:0] float_cycles(
    input logic is_temp,
    input logic [1:0] sel
  );
    logic [CNT_W-1:0] n;
    n = '0;
    case (sel)
      2'h0: n = CNT_W'(SHORT_CYC);
      2'h1: n = is_temp ? CNT_W'(OT_MID_CYCLES)
                        : CNT_W'(dsp_regs_pkg::OC_MID_CYC);
      2'h2: n = is_temp ? CNT_W'(OT_LONG_CYCLES) : CNT_W'(OC_LONG_CYCLES);
      default: n = '0;
    endcase
    return n;
  endfunction

  // Register writes; reserved bits are simply not stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bypass_reg.overcurrent_retry_delay <= dsp_regs_pkg::OC_RETRY_RST;
      bypass_reg.overtemp_retry_delay <= dsp_regs_pkg::OT_RETRY_RST;
      bypass_reg.soft_clip_disable <= dsp_regs_pkg::SOFT_CLIP_RST;
      bypass_reg.highpass_skip <= dsp_regs_pkg::HIGHPASS_RST;
      bypass_reg.compressor_skip <= dsp_regs_pkg::COMPRESSOR_RST;
      bypass_reg.equalizer_skip <= dsp_regs_pkg::EQUALIZER_RST;
    end else if (reg_wr && reg_addr == dsp_regs_pkg::ADDR_PROT_BYPASS) begin
      bypass_reg.overcurrent_retry_delay <=
        reg_wdata[dsp_regs_pkg::OC_RETRY_LSB +: 2];
      bypass_reg.overtemp_retry_delay <=
        reg_wdata[dsp_regs_pkg::OT_RETRY_LSB +: 2];
      bypass_reg.soft_clip_disable <=
        reg_wdata[dsp_regs_pkg::SOFT_CLIP_BIT];
      bypass_reg.highpass_skip <= reg_wdata[dsp_regs_pkg::HIGHPASS_BIT];
      bypass_reg.compressor_skip <=
        reg_wdata[dsp_regs_pkg::COMPRESSOR_BIT];
      bypass_reg.equalizer_skip <=
        reg_wdata[dsp_regs_pkg::EQUALIZER_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      comp_reg.compress_onset_level <= dsp_regs_pkg::ONSET_LEVEL_RST;
      comp_reg.compress_onset_speed <= dsp_regs_pkg::ONSET_SPEED_RST;
      comp_reg.compress_release_level <=
        dsp_regs_pkg::RELEASE_LEVEL_RST;
      comp_reg.compress_release_speed <=
        dsp_regs_pkg::RELEASE_SPEED_RST;
    end else if (reg_wr && reg_addr == dsp_regs_pkg::ADDR_COMPRESSOR) begin
      comp_reg.compress_onset_level <=
        reg_wdata[dsp_regs_pkg::ONSET_LEVEL_LSB +: 4];
      comp_reg.compress_onset_speed <=
        reg_wdata[dsp_regs_pkg::ONSET_SPEED_LSB +: 4];
      comp_reg.compress_release_level <=
        reg_wdata[dsp_regs_pkg::RELEASE_LEVEL_LSB +: 4];
      comp_reg.compress_release_speed <=
        reg_wdata[dsp_regs_pkg::RELEASE_SPEED_LSB +: 4];
    end
  end

  // Reserved gain codes are stored as written so software reads them back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tone_reg.high_shelf_gain <= dsp_regs_pkg::SHELF_GAIN_RST;
      tone_reg.high_shelf_corner <= dsp_regs_pkg::SHELF_CORNER_RST;
      tone_reg.low_shelf_gain <= dsp_regs_pkg::SHELF_GAIN_RST;
      tone_reg.low_shelf_corner <= dsp_regs_pkg::SHELF_CORNER_RST;
    end else if (reg_wr && reg_addr == dsp_regs_pkg::ADDR_TONE) begin
      tone_reg.high_shelf_gain <=
        reg_wdata[dsp_regs_pkg::HIGH_GAIN_LSB +: 5];
      tone_reg.high_shelf_corner <=
        reg_wdata[dsp_regs_pkg::HIGH_CORNER_LSB +: 2];
      tone_reg.low_shelf_gain <=
        reg_wdata[dsp_regs_pkg::LOW_GAIN_LSB +: 5];
      tone_reg.low_shelf_corner <=
        reg_wdata[dsp_regs_pkg::LOW_CORNER_LSB +: 2];
    end
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == dsp_regs_pkg::ADDR_PROT_BYPASS) begin
          rdata_reg <= {8'h00, bypass_reg};
        end else if (reg_addr == dsp_regs_pkg::ADDR_COMPRESSOR) begin
          rdata_reg <= comp_reg;
        end else if (reg_addr == dsp_regs_pkg::ADDR_TONE) begin
          rdata_reg <= {2'h0, tone_reg};
        end else begin
          rdata_reg <= 16'h0000;
        end
      end
    end
  end

  tone_gain_decode u_high_gain (
    .code(tone_reg.high_shelf_gain),
    .gain_db(high_db_next)
  );

  tone_gain_decode u_low_gain (
    .code(tone_reg.low_shelf_gain),
    .gain_db(low_db_next)
  );

  // Registered so downstream filters see a clean one-cycle-late value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      high_db_reg <= dsp_regs_pkg::SHELF_GAIN_ZERO_DB;
      low_db_reg <= dsp_regs_pkg::SHELF_GAIN_ZERO_DB;
    end else begin
      high_db_reg <= high_db_next;
      low_db_reg <= low_db_next;
    end
  end

  assign oc_load = float_cycles(1'b0, bypass_reg.overcurrent_retry_delay);
  assign ot_load = float_cycles(1'b1, bypass_reg.overtemp_retry_delay);
  assign oc_hold = overcurrent_event &&
    bypass_reg.overcurrent_retry_delay == dsp_regs_pkg::RETRY_HOLD;
  assign ot_hold = overtemp_event &&
    bypass_reg.overtemp_retry_delay == dsp_regs_pkg::RETRY_HOLD;

  // Float timer; a fresh fault only ever lengthens the remaining float
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= dsp_regs_pkg::FLOAT_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        dsp_regs_pkg::FLOAT_HELD: begin
          cnt_reg <= '0;
        end
        default: begin
          if (oc_hold || ot_hold) begin
            state_reg <= dsp_regs_pkg::FLOAT_HELD;
            cnt_reg <= '0;
          end else if ((overcurrent_event && oc_load > cnt_reg) ||
                       (overtemp_event && ot_load > cnt_reg)) begin
            state_reg <= dsp_regs_pkg::FLOAT_TIMED;
            if (overcurrent_event && overtemp_event) begin
              cnt_reg <= (oc_load > ot_load) ? oc_load : ot_load;
            end else if (overcurrent_event) begin
              cnt_reg <= oc_load;
            end else begin
              cnt_reg <= ot_load;
            end
          end else if (state_reg == dsp_regs_pkg::FLOAT_TIMED) begin
            if (cnt_reg == CNT_W'(1)) begin
              state_reg <= dsp_regs_pkg::FLOAT_IDLE;
            end
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
      endcase
    end
  end

  assign stage_float = state_reg != dsp_regs_pkg::FLOAT_IDLE;
  assign cfg_bypass = bypass_reg;
  assign cfg_compressor = comp_reg;
  assign cfg_tone = tone_reg;
  assign high_shelf_db = high_db_reg;
  assign low_shelf_db = low_db_reg;
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  a_oc_short_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (overcurrent_event && !overtemp_event && !stage_float &&
     bypass_reg.overcurrent_retry_delay == 2'h0)
    |=> stage_float[*8] ##(SHORT_CYC - 7) !stage_float)
    else $error("overcurrent short float length wrong");

  a_oc_hold_float: assert property (@(posedge mclk) disable iff (!rst_n)
    oc_hold |=> (state_reg == dsp_regs_pkg::FLOAT_HELD) [*8])
    else $error("overcurrent hold did not stick");

  a_ot_mid_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (overtemp_event && !overcurrent_event && !stage_float &&
     bypass_reg.overtemp_retry_delay == 2'h1)
    |=> cnt_reg == CNT_W'(OT_MID_CYCLES))
    else $error("overtemperature mid float not loaded");

  a_float_end_count: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $fell(stage_float) |-> $past(cnt_reg) == CNT_W'(1))
    else $error("float ended before count ran out");

  a_bypass_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == dsp_regs_pkg::ADDR_PROT_BYPASS)
    |=> cfg_bypass.soft_clip_disable == $past(reg_wdata[3]) &&
        cfg_bypass.highpass_skip == $past(reg_wdata[2]))
    else $error("bypass write not applied");

  a_skip_reset: assert property (@(posedge mclk)
    !rst_n |=> cfg_bypass.compressor_skip && cfg_bypass.equalizer_skip &&
              !cfg_bypass.highpass_skip && !cfg_bypass.soft_clip_disable)
    else $error("bypass reset values wrong");

  a_comp_reset: assert property (@(posedge mclk)
    !rst_n |=> cfg_compressor == 16'h92BA)
    else $error("compressor reset value wrong");

  a_tone_reset: assert property (@(posedge mclk)
    !rst_n |=> cfg_tone == 14'h12A5)
    else $error("tone reset value wrong");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && (reg_addr == dsp_regs_pkg::ADDR_PROT_BYPASS ||
                reg_addr == dsp_regs_pkg::ADDR_TONE))
    |=> reg_rvalid && reg_rdata[15:14] == 2'h0 &&
        (reg_rdata[15:8] == 8'h00 ||
         $past(reg_addr) == dsp_regs_pkg::ADDR_TONE))
    else $error("reserved bits read non-zero");

  a_gain_linear: assert property (@(posedge mclk) disable iff (!rst_n)
    (tone_reg.high_shelf_gain <= 5'h12 && $stable(tone_reg.high_shelf_gain))
    |=> high_shelf_db ==
        6'(-18 + 2 * int'($past(tone_reg.high_shelf_gain))))
    else $error("treble gain decode wrong");

  a_gain_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    (tone_reg.low_shelf_gain > 5'h12) |=> low_shelf_db == 6'sd0)
    else $error("reserved bass code not flat");

endmodule

// *** verif/audio_dsp_bypass_tone_regs_tb.sv ***
// Self-checking bench for the sound chain configuration registers
`timescale 1ns/1ns
module audio_dsp_bypass_tone_regs_tb;
  // Shortened long floats keep the run brief; all stay above the short count
  localparam int OC_LONG = 300;
  localparam int OT_MID = 400;
  localparam int OT_LONG = 500;
  localparam int HOLD_LIMIT = 1200;
  logic mclk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic overcurrent_event;
  logic overtemp_event;
  logic stage_float;
  dsp_regs_pkg::protect_bypass_t cfg_bypass;
  dsp_regs_pkg::compressor_t cfg_compressor;
  dsp_regs_pkg::tone_t cfg_tone;
  logic signed [5:0] high_shelf_db;
  logic signed [5:0] low_shelf_db;
  int fails;
  int checked;
  int cnt;
  logic [15:0] w;

  audio_dsp_bypass_tone_regs #(
    .CNT_W(25),
    .OC_LONG_CYCLES(OC_LONG),
    .OT_MID_CYCLES(OT_MID),
    .OT_LONG_CYCLES(OT_LONG)
  ) dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .overcurrent_event(overcurrent_event),
    .overtemp_event(overtemp_event),
    .stage_float(stage_float),
    .cfg_bypass(cfg_bypass),
    .cfg_compressor(cfg_compressor),
    .cfg_tone(cfg_tone),
    .high_shelf_db(high_shelf_db),
    .low_shelf_db(low_shelf_db)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input string what);
    int i;
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 3) begin
      @(negedge mclk);
      i++;
    end
    chk({what, " rvalid"}, 16'h0001, {15'h0, reg_rvalid});
    chk(what, exp, reg_rdata);
  endtask

  task automatic do_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
  endtask

  // Reset contents seen both on the read port and on the field outputs
  task automatic chk_defaults();
    rd(dsp_regs_pkg::ADDR_PROT_BYPASS, 16'h0093,
       "bypass reset");
    rd(dsp_regs_pkg::ADDR_COMPRESSOR, 16'h92BA, "comp reset");
    rd(dsp_regs_pkg::ADDR_TONE, 16'h12A5, "tone reset");
    chk("cfg_bypass", 16'h0093, {8'h0, cfg_bypass});
    chk("cfg_compressor", 16'h92BA, cfg_compressor);
    chk("cfg_tone", 16'h12A5, {2'h0, cfg_tone});
    chk("treble db", 16'h0000, {10'h0, high_shelf_db});
    chk("bass db", 16'h0000, {10'h0, low_shelf_db});
  endtask

  function automatic logic [5:0] db_of(input logic [4:0] c);
    // Reserved codes must never yield a boost beyond the top step
    return (c > 5'h12) ? 6'h00 : 6'(-18 + 2 * int'(c));
  endfunction

  task automatic pulse(input logic temp);
    @(negedge mclk);
    if (temp) overtemp_event = 1'b1;
    else overcurrent_event = 1'b1;
    @(negedge mclk);
    overtemp_event = 1'b0;
    overcurrent_event = 1'b0;
  endtask

  task automatic count_float();
    while (stage_float === 1'b1 && cnt < HOLD_LIMIT) begin
      cnt++;
      @(negedge mclk);
    end
  endtask

  task automatic fault(input logic temp, input logic [1:0] sel,
                       input int exp);
    if (temp) wr(dsp_regs_pkg::ADDR_PROT_BYPASS, {10'h0, sel, 4'h3});
    else wr(dsp_regs_pkg::ADDR_PROT_BYPASS, {8'h0, sel, 6'h03});
    pulse(temp);
    cnt = 0;
    count_float();
    chk("float cycles", exp[15:0], cnt[15:0]);
  endtask

  initial begin
    #(20000 * 40);
    fails++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    overcurrent_event = 1'b0;
    overtemp_event = 1'b0;
    fails = 0;
    checked = 0;
    cnt = 0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk_defaults();
    // Walking one across every bit, reserved places included
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      wr(dsp_regs_pkg::ADDR_PROT_BYPASS, w);
      wr(dsp_regs_pkg::ADDR_COMPRESSOR, w);
      wr(dsp_regs_pkg::ADDR_TONE, w);
      rd(dsp_regs_pkg::ADDR_PROT_BYPASS, w & 16'h00FF, "bypass");
      rd(dsp_regs_pkg::ADDR_COMPRESSOR, w, "comp");
      rd(dsp_regs_pkg::ADDR_TONE, w & 16'h3FFF, "tone");
      chk("cfg_bypass", w & 16'h00FF, {8'h0, cfg_bypass});
      chk("cfg_compressor", w, cfg_compressor);
      chk("cfg_tone", w & 16'h3FFF, {2'h0, cfg_tone});
    end
    // Every gain code on both shelves, reserved codes among them
    for (int c = 0; c < 32; c++) begin
      w = {2'h3, c[4:0], c[1:0], ~c[4:0], ~c[1:0]};
      wr(dsp_regs_pkg::ADDR_TONE, w);
      rd(dsp_regs_pkg::ADDR_TONE, w & 16'h3FFF,
         "tone code");
      chk("treble db", {10'h0, db_of(c[4:0])},
          {10'h0, high_shelf_db});
      chk("bass db", {10'h0, db_of(~c[4:0])},
          {10'h0, low_shelf_db});
    end
    // Unmapped places neither store nor disturb the tone register
    wr(8'h12, 16'hFFFF);
    wr(8'h0E, 16'hFFFF);
    rd(8'h12, 16'h0000, "unmapped 12");
    rd(8'h0E, 16'h0000, "unmapped 0E");
    rd(dsp_regs_pkg::ADDR_TONE, w & 16'h3FFF, "tone kept");
    // Timed floats for selectors 0 to 2 of both faults
    fault(1'b0, 2'h0, dsp_regs_pkg::FLOAT_SHORT_CYC);
    fault(1'b0, 2'h1, dsp_regs_pkg::OC_MID_CYC);
    fault(1'b0, 2'h2, OC_LONG);
    fault(1'b1, 2'h0, dsp_regs_pkg::FLOAT_SHORT_CYC);
    fault(1'b1, 2'h1, OT_MID);
    fault(1'b1, 2'h2, OT_LONG);
    // A shorter fault during a longer float must not cut it short
    wr(dsp_regs_pkg::ADDR_PROT_BYPASS, 16'h0043);
    pulse(1'b0);
    cnt = 0;
    repeat (100) begin
      cnt++;
      @(negedge mclk);
    end
    pulse(1'b1);
    cnt = cnt + 2;
    count_float();
    chk("float reload", 16'(dsp_regs_pkg::OC_MID_CYC), cnt[15:0]);
    // Both faults in one cycle take the longer of the two floats
    @(negedge mclk);
    overcurrent_event = 1'b1;
    overtemp_event = 1'b1;
    @(negedge mclk);
    overcurrent_event = 1'b0;
    overtemp_event = 1'b0;
    cnt = 0;
    count_float();
    chk("float both", 16'(dsp_regs_pkg::OC_MID_CYC), cnt[15:0]);
    // No-recovery selectors hold the stage until reset
    fault(1'b0, 2'h3, HOLD_LIMIT);
    do_reset();
    chk("float after reset", 16'h0000, {15'h0, stage_float});
    fault(1'b1, 2'h3, HOLD_LIMIT);
    do_reset();
    chk_defaults();
    print_verdict();
  end
endmodule
